//--- core/uca_port.sv
// Second serial port: control register, data buffer, address match, shifter.
// Assumes an APB master on clk_sys; rxd is asynchronous and synchronised here.
`timescale 1ns/1ps

module uca_port
	import uca_pkg::*;
#(
	parameter int unsigned DIV_W = 16
) (
	input  wire logic              clk_sys,
	input  wire logic              reset_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              rxd,
	input  wire logic              int_enable,
	output logic                   txd,
	output logic                   sclk,
	output logic                   irq
);

	if (DIV_W < 4 || DIV_W > 24) begin : g_bad_div
		$error("DIV_W must lie between 4 and 24");
	end

	uca_ctrl_t          ctrl_q;
	logic               fe_q;
	logic               rxov_q;
	logic               txcol_q;
	logic               view_sel_q;
	logic [7:0]         saddr_q;
	logic [7:0]         mask_q;
	logic [7:0]         rxbuf_q;
	logic               unread_q;
	logic [DIV_W-1:0]   div_q;
	logic [31:0]        prdata_q;
	logic               pready_q;
	logic               pslverr_q;
	logic               irq_q;
	logic               rxd_m_q;
	logic               rxd_s_q;
	logic [DIV_W-1:0]   os_cnt_q;
	uca_tx_st_t         tx_st_q;
	logic [9:0]         tx_sh_q;
	logic [3:0]         tx_left_q;
	logic [3:0]         tx_os_q;
	logic [3:0]         m0_cnt_q;
	logic               m0_rx_q;
	logic               txd_q;
	logic               sclk_q;
	uca_rx_st_t         rx_st_q;
	logic [3:0]         rx_os_q;
	logic [3:0]         rx_left_q;
	logic [8:0]         rx_sh_q;
	logic [31:0]        rdata_d;

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign txd     = txd_q;
	assign sclk    = sclk_q;
	assign irq     = irq_q;

	// Bus decode
	wire setup    = psel & ~penable;
	wire acc      = psel & penable & pready_q;
	wire wr       = acc & pwrite;
	wire rd       = acc & ~pwrite;
	wire hit_mask = paddr == ADR_ADDRESS_MASK;
	wire hit_ctl  = paddr == ADR_PORT_CONTROL;
	wire hit_buf  = paddr == ADR_DATA_BUFFER;
	wire hit_addr = paddr == ADR_OWN_SLAVE_ADDRESS;
	wire hit_aux  = paddr == ADR_AUX_CONTROL;
	wire hit_div  = paddr == ADR_BIT_DIVISOR;
	wire mapped   = hit_mask | hit_ctl | hit_buf | hit_addr | hit_aux | hit_div;
	wire wr_ctl   = wr & hit_ctl;
	wire wr_buf   = wr & hit_buf;
	wire rd_buf   = rd & hit_buf;
	wire [7:0] wbyte = pwdata[7:0];

	// Mode decode from the settings bits, independent of the view
	wire uca_mode_t mode = uca_mode_t'({ctrl_q.mode_select_high, ctrl_q.mode_select_low});
	wire sync      = mode == MODE_SYNC;
	wire nine_bit  = (mode == MODE_9FIX) | (mode == MODE_9VAR);
	wire mp_en     = ctrl_q.multiprocessor_enable & ~sync;

	// Status view overlays bits 7-5 only
	wire [7:0] ctl_view = view_sel_q ? {fe_q, rxov_q, txcol_q, ctrl_q[4:0]} : ctrl_q;

	always_comb begin
		rdata_d = '0;
		if (hit_mask) begin
			rdata_d[7:0] = mask_q;
		end else if (hit_ctl) begin
			rdata_d[7:0] = ctl_view;
		end else if (hit_buf) begin
			rdata_d[7:0] = rxbuf_q;
		end else if (hit_addr) begin
			rdata_d[7:0] = saddr_q;
		end else if (hit_aux) begin
			rdata_d[AUX_VIEW_SEL_POS] = view_sel_q;
		end else if (hit_div) begin
			rdata_d[DIV_W-1:0] = div_q;
		end
	end

	// One wait-free access phase: data captured in setup, ready in access
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			pready_q  <= 1'b0;
			prdata_q  <= '0;
			pslverr_q <= 1'b0;
		end else begin
			pready_q <= setup;
			if (setup) begin
				prdata_q  <= rdata_d;
				pslverr_q <= ~mapped;
			end
		end
	end

	// Input synchroniser
	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rxd_m_q <= 1'b1;
			rxd_s_q <= 1'b1;
		end else begin
			rxd_m_q <= rxd;
			rxd_s_q <= rxd_m_q;
		end
	end

	// Oversample enable: sixteen per bit; fixed rate mode ignores the divisor
	wire [DIV_W-1:0] os_reload = (mode == MODE_9FIX) ? DIV_W'(MODE2_OS_CYC - 1) : div_q;
	wire             os_tick   = os_cnt_q == '0;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			os_cnt_q <= '0;
		end else begin
			os_cnt_q <= os_tick ? os_reload : os_cnt_q - 1'b1;
		end
	end

	// Shift engine; in sync mode it also clocks reception
	wire tx_busy   = tx_st_q != TX_IDLE;
	wire tx_start  = wr_buf & ~tx_busy;
	wire m0_start  = sync & ctrl_q.receive_enable & ~ctrl_q.rx_done_flag & ~tx_busy & ~wr_buf;
	wire bit_end   = sync ? (m0_cnt_q == M0_LAST) : (os_tick & (tx_os_q == OS_LAST));
	wire last_bit  = (tx_st_q == TX_DATA) & bit_end & (tx_left_q == 4'h1);
	wire tx_done   = last_bit & ~m0_rx_q;
	wire m0_rx_end = last_bit & m0_rx_q;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			tx_st_q   <= TX_IDLE;
			tx_sh_q   <= '0;
			tx_left_q <= '0;
			tx_os_q   <= '0;
			m0_cnt_q  <= '0;
			m0_rx_q   <= 1'b0;
			txd_q     <= 1'b1;
			sclk_q    <= 1'b1;
		end else begin
			case (tx_st_q)
				TX_IDLE: begin
					txd_q    <= 1'b1;
					sclk_q   <= 1'b1;
					tx_os_q  <= '0;
					m0_cnt_q <= '0;
					if (tx_start) begin
						tx_st_q <= TX_DATA;
						m0_rx_q <= 1'b0;
						if (sync) begin
							tx_sh_q   <= {2'b11, wbyte};
							tx_left_q <= BITS_SYNC;
						end else if (nine_bit) begin
							tx_sh_q   <= {ctrl_q.tx_ninth_bit, wbyte, 1'b0};
							tx_left_q <= BITS_ASYNC9;
						end else begin
							tx_sh_q   <= {1'b1, wbyte, 1'b0};
							tx_left_q <= BITS_ASYNC8;
						end
					end else if (m0_start) begin
						tx_st_q   <= TX_DATA;
						m0_rx_q   <= 1'b1;
						tx_sh_q   <= 10'h3ff;
						tx_left_q <= BITS_SYNC;
					end
				end
				TX_DATA: begin
					txd_q  <= m0_rx_q ? 1'b1 : tx_sh_q[0];
					sclk_q <= sync ? (m0_cnt_q >= M0_HALF) : 1'b1;
					if (sync) begin
						m0_cnt_q <= bit_end ? 4'h0 : m0_cnt_q + 4'h1;
					end else if (os_tick) begin
						tx_os_q <= tx_os_q + 4'h1;
					end
					if (bit_end) begin
						tx_sh_q   <= {1'b1, tx_sh_q[9:1]};
						tx_left_q <= tx_left_q - 4'h1;
						if (tx_left_q == 4'h1) begin
							tx_st_q <= sync ? TX_IDLE : TX_STOP;
						end
					end
				end
				TX_STOP: begin
					txd_q <= 1'b1;
					if (os_tick) begin
						tx_os_q <= tx_os_q + 4'h1;
					end
					if (bit_end) begin
						tx_st_q <= TX_IDLE;
					end
				end
				default: begin
					tx_st_q <= TX_IDLE;
				end
			endcase
		end
	end

	// Asynchronous receiver
	wire rx_en    = ctrl_q.receive_enable & ~sync;
	wire stop_ev  = (rx_st_q == RX_STOP) & os_tick & (rx_os_q == OS_LAST);
	wire stop_bit = rxd_s_q;
	wire [7:0] rx_byte = nine_bit ? rx_sh_q[7:0] : rx_sh_q[8:1];
	wire ninth    = rx_sh_q[8];
	wire [7:0] bcast    = saddr_q | mask_q;
	wire own_hit  = ((rx_byte ^ saddr_q) & mask_q) == 8'h00;
	wire bc_hit   = (rx_byte & bcast) == bcast;
	wire addr_hit = own_hit | bc_hit;
	wire accept   = nine_bit ? (~mp_en | (ninth & addr_hit)) : (~mp_en | stop_bit);
	wire async_latch = stop_ev & accept;
	wire latch_ev = async_latch | m0_rx_end;
	wire [7:0] latch_byte = m0_rx_end ? {rxd_s_q, rx_sh_q[8:2]} : rx_byte;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			rx_st_q   <= RX_IDLE;
			rx_os_q   <= '0;
			rx_left_q <= '0;
			rx_sh_q   <= '0;
		end else if (!rx_en) begin
			rx_st_q <= RX_IDLE;
			if (m0_rx_q && (tx_st_q == TX_DATA) && bit_end) begin
				rx_sh_q <= {rxd_s_q, rx_sh_q[8:1]};
			end
		end else begin
			if (os_tick && rx_st_q != RX_IDLE) begin
				rx_os_q <= rx_os_q + 4'h1;
			end
			case (rx_st_q)
				RX_IDLE: begin
					rx_os_q <= '0;
					if (!rxd_s_q) begin
						rx_st_q <= RX_START;
					end
				end
				RX_START: begin
					if (os_tick && rx_os_q == OS_MID) begin
						rx_os_q   <= '0;
						rx_left_q <= nine_bit ? 4'h9 : 4'h8;
						rx_st_q   <= rxd_s_q ? RX_IDLE : RX_DATA;
					end
				end
				RX_DATA: begin
					if (os_tick && rx_os_q == OS_LAST) begin
						rx_sh_q   <= {rxd_s_q, rx_sh_q[8:1]};
						rx_left_q <= rx_left_q - 4'h1;
						if (rx_left_q == 4'h1) begin
							rx_st_q <= RX_STOP;
						end
					end
				end
				RX_STOP: begin
					if (stop_ev) begin
						rx_st_q <= RX_IDLE;
					end
				end
				default: begin
					rx_st_q <= RX_IDLE;
				end
			endcase
		end
	end

	// Registers; hardware set beats a software clear in the same cycle
	wire fe_set    = stop_ev & ~stop_bit;
	wire rxov_set  = async_latch & unread_q;
	wire txcol_set = wr_buf & tx_busy;
	wire stat_wr   = wr_ctl & view_sel_q;

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			ctrl_q     <= RST_BYTE;
			saddr_q    <= RST_BYTE;
			mask_q     <= RST_BYTE;
			rxbuf_q    <= RST_BYTE;
			view_sel_q <= 1'b0;
			div_q      <= DIV_W'(RST_BIT_DIVISOR);
			fe_q       <= 1'b0;
			rxov_q     <= 1'b0;
			txcol_q    <= 1'b0;
			unread_q   <= 1'b0;
			irq_q      <= 1'b0;
		end else begin
			if (wr_ctl && view_sel_q) begin
				ctrl_q[4:0] <= wbyte[4:0];
			end else if (wr_ctl) begin
				ctrl_q <= wbyte;
			end
			if (tx_done) begin
				ctrl_q.tx_done_flag <= 1'b1;
			end
			if (latch_ev) begin
				ctrl_q.rx_done_flag <= 1'b1;
				rxbuf_q             <= latch_byte;
			end
			if (async_latch) begin
				ctrl_q.rx_ninth_bit <= nine_bit ? ninth : stop_bit;
			end
			if (wr & hit_addr) begin
				saddr_q <= wbyte;
			end
			if (wr & hit_mask) begin
				mask_q <= wbyte;
			end
			if (wr & hit_aux) begin
				view_sel_q <= pwdata[AUX_VIEW_SEL_POS];
			end
			if (wr & hit_div) begin
				div_q <= pwdata[DIV_W-1:0];
			end
			fe_q     <= fe_set | (stat_wr ? wbyte[7] : fe_q);
			rxov_q   <= rxov_set | (stat_wr ? wbyte[6] : rxov_q);
			txcol_q  <= txcol_set | (stat_wr ? wbyte[5] : txcol_q);
			unread_q <= latch_ev | (unread_q & ~rd_buf);
			irq_q    <= int_enable & (ctrl_q.tx_done_flag | ctrl_q.rx_done_flag);
		end
	end

	// Checks
	txcol_set_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wr_buf && tx_busy |=> txcol_q)
		else $error("collision flag not set on busy write");

	tx_start_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		wr_buf && !tx_busy |=> tx_st_q == TX_DATA ##1 tx_st_q == TX_DATA)
		else $error("data write did not start a transfer");

	rd_latch_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		setup && hit_buf && !pwrite |=> prdata_q[7:0] == $past(rxbuf_q))
		else $error("buffer read not from receive latch");

	flag_hold_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		ctrl_q.rx_done_flag && !wr_ctl |=> ctrl_q.rx_done_flag)
		else $error("receive flag cleared by hardware");

	rx_off_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		!ctrl_q.receive_enable |=> rx_st_q == RX_IDLE && !async_latch)
		else $error("receiver active while disabled");

	frame_err_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		stop_ev && !stop_bit |=> fe_q)
		else $error("framing error not flagged");

	overrun_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		async_latch && unread_q |=> rxov_q && unread_q)
		else $error("overrun not flagged");

	mp_reject_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		stop_ev && nine_bit && mp_en && (!ninth || !addr_hit) && !ctrl_q.rx_done_flag
		&& !wr_ctl |=> !ctrl_q.rx_done_flag)
		else $error("unaddressed byte raised receive flag");

	tx_flag_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		$rose(tx_st_q == TX_STOP) |-> ctrl_q.tx_done_flag ##1 txd_q)
		else $error("transmit flag missing at stop bit");

	irq_req_a: assert property (@(posedge clk_sys) disable iff (!reset_n)
		int_enable && ctrl_q.tx_done_flag |=> irq)
		else $error("interrupt not requested");

	reset_zero_a: assert property (@(posedge clk_sys)
		!$past(reset_n) |-> ctrl_q == RST_BYTE && saddr_q == RST_BYTE && mask_q == RST_BYTE)
		else $error("port registers not zero after reset");

endmodule

//--- core/uca_pkg.sv
// Constants, types and register map of the serial port control block.
// Assumes a 32-bit APB with word-aligned registers; index times four is the byte address.
package uca_pkg;

	localparam int unsigned ADDR_W = 10;

	// Register indices; byte address is the index times four
	localparam logic [7:0] IDX_ADDRESS_MASK      = 8'hae;
	localparam logic [7:0] IDX_PORT_CONTROL      = 8'hf1;
	localparam logic [7:0] IDX_DATA_BUFFER       = 8'hf2;
	localparam logic [7:0] IDX_OWN_SLAVE_ADDRESS = 8'hf3;
	localparam logic [7:0] IDX_AUX_CONTROL       = 8'hf4;
	localparam logic [7:0] IDX_BIT_DIVISOR       = 8'hf5;

	localparam logic [ADDR_W-1:0] ADR_ADDRESS_MASK      = {IDX_ADDRESS_MASK, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_PORT_CONTROL      = {IDX_PORT_CONTROL, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_DATA_BUFFER       = {IDX_DATA_BUFFER, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_OWN_SLAVE_ADDRESS = {IDX_OWN_SLAVE_ADDRESS, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_AUX_CONTROL       = {IDX_AUX_CONTROL, 2'h0};
	localparam logic [ADDR_W-1:0] ADR_BIT_DIVISOR       = {IDX_BIT_DIVISOR, 2'h0};

	// Reset values
	localparam logic [7:0]  RST_BYTE        = 8'h00;
	localparam logic [15:0] RST_BIT_DIVISOR = 16'h001a;

	// Field position in the auxiliary control register
	localparam int unsigned AUX_VIEW_SEL_POS = 0;

	// Timing counts in system clock cycles, oversample ticks and bits
	localparam logic [3:0]  OS_LAST       = 4'hf;
	localparam logic [3:0]  OS_MID        = 4'h7;
	localparam logic [3:0]  M0_LAST       = 4'hb;
	localparam logic [3:0]  M0_HALF       = 4'h6;
	localparam int unsigned MODE2_OS_CYC  = 4;
	localparam logic [3:0]  BITS_SYNC     = 4'h8;
	localparam logic [3:0]  BITS_ASYNC8   = 4'h9;
	localparam logic [3:0]  BITS_ASYNC9   = 4'ha;

	typedef enum logic [1:0] {
		MODE_SYNC  = 2'b00,
		MODE_8VAR  = 2'b01,
		MODE_9FIX  = 2'b10,
		MODE_9VAR  = 2'b11
	} uca_mode_t;

	// Port control layout; status view reuses bits 7-5
	typedef struct packed {
		logic mode_select_high;
		logic mode_select_low;
		logic multiprocessor_enable;
		logic receive_enable;
		logic tx_ninth_bit;
		logic rx_ninth_bit;
		logic tx_done_flag;
		logic rx_done_flag;
	} uca_ctrl_t;

	typedef enum logic [1:0] {TX_IDLE, TX_DATA, TX_STOP} uca_tx_st_t;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} uca_rx_st_t;

endpackage

//--- dv/uca_node_model.sv
// Far-side serial node: sends frames on rxd and decodes frames seen on txd.
// Assumes the bench sets cpb (cycles per bit) and nbits (frame length) first.
`timescale 1ns/1ps

module uca_node_model (
	input  wire logic clk_sys,
	input  wire logic txd,
	input  wire logic sclk,
	output logic      rxd
);
	int          cpb = 16;
	int          nbits = 11;
	int          got_cnt = 0;
	logic [10:0] sh;
	logic [7:0]  got_byte;
	logic        got_ninth;
	int          sclk_cnt = 0;
	logic [7:0]  sync_byte;

	// Idle line rests at mark level
	initial rxd = 1'b1;

	// Sync mode: one bit per rising shift clock, LSB first; the bench counts relative
	always @(posedge sclk) begin
		sync_byte <= {txd, sync_byte[7:1]};
		sclk_cnt  <= sclk_cnt + 1;
	end

	// Start, data LSB first, optional ninth bit, stop
	task automatic send(input logic [7:0] b, input logic n9, input logic st);
		logic [10:0] f;
		f = (nbits == 11) ? {st, n9, b, 1'b0} : {1'b1, st, b, 1'b0};
		for (int i = 0; i < nbits; i++) begin
			@(posedge clk_sys);
			rxd <= f[i];
			repeat (cpb - 1) @(posedge clk_sys);
		end
		@(posedge clk_sys);
		rxd <= 1'b1;
	endtask

	// Mid-bit sampling keeps clear of the design's own edges
	initial forever begin
		@(negedge txd);
		repeat (cpb / 2) @(posedge clk_sys);
		for (int i = 0; i < nbits; i++) begin
			sh[i] = txd;
			repeat (cpb) @(posedge clk_sys);
		end
		got_byte = sh[8:1];
		got_ninth = sh[9];
		got_cnt++;
	end
endmodule

//--- dv/uca_port_tb.sv
// Self-checking bench for the serial port block: APB tasks plus a serial node.
// Assumes zero-wait APB answers are not relied on; bit divisor is set to 0.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin errors++; \
	$display("FAIL %s expected %h seen %h", nm, ex, got); end end

module uca_port_tb import uca_pkg::*;;
	localparam logic [ADDR_W-1:0] REGS [4] = '{ADR_ADDRESS_MASK, ADR_PORT_CONTROL,
		ADR_DATA_BUFFER, ADR_OWN_SLAVE_ADDRESS};
	logic              clk_sys;
	logic              reset_n;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              rxd;
	logic              int_enable;
	logic              txd;
	logic              sclk;
	logic              irq;
	logic [31:0]       rdat;
	logic              rerr;
	int                errors = 0;
	int                tests_run = 0;
	int                cycles = 0;
	int                c0;
	int                n;

	uca_port uca_port_i (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxd(rxd), .int_enable(int_enable), .txd(txd), .sclk(sclk),
		.irq(irq));

	uca_node_model uca_node_model_i (.clk_sys(clk_sys), .txd(txd), .sclk(sclk), .rxd(rxd));

	always #10 clk_sys = ~clk_sys;

	task automatic report_and_stop();
		if (errors == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Run length is a few thousand cycles; the ceiling leaves ample margin
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 30000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
		int k;
		k = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h000000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		// Ready, read data and error are all taken at the completing rising edge
		do begin
			@(posedge clk_sys);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (pready !== 1'b1)
			errors++;
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input string nm, input logic [ADDR_W-1:0] a, input logic [7:0] ex);
		apb(1'b0, a, 8'h00);
		`CHK(nm, ex, rdat[7:0])
	endtask

	// Flags cleared on entry, so rx_ninth stays 0 unless a byte is taken
	task automatic rx_case(input logic [1:0] m, input logic mp, input logic ren,
		input logic [7:0] b, input logic n9, input logic st, input logic acc, input logic rb8);
		uca_node_model_i.cpb = (m == 2'b10) ? 64 : 16;
		uca_node_model_i.nbits = (m == 2'b01) ? 10 : 11;
		wr(ADR_AUX_CONTROL, 8'h00);
		wr(ADR_PORT_CONTROL, {m, mp, ren, 4'h0});
		uca_node_model_i.send(b, n9, st);
		repeat (8) @(posedge clk_sys);
		rdc("rx control", ADR_PORT_CONTROL, {m, mp, ren, 1'b0, rb8, 1'b0, acc});
		if (acc)
			rdc("rx data", ADR_DATA_BUFFER, b);
	endtask

	initial begin
		clk_sys = 1'b0;
		reset_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		int_enable = 1'b0;
		repeat (12) @(posedge clk_sys);
		reset_n <= 1'b1;
		foreach (REGS[i]) rdc("reset value", REGS[i], 8'h00);
		apb(1'b0, 10'h004, 8'h00);
		`CHK("unmapped error", 1'b1, rerr)
		wr(ADR_BIT_DIVISOR, 8'h00);
		wr(ADR_OWN_SLAVE_ADDRESS, 8'h35);
		rdc("own address", ADR_OWN_SLAVE_ADDRESS, 8'h35);
		wr(ADR_ADDRESS_MASK, 8'h0f);
		rdc("mask", ADR_ADDRESS_MASK, 8'h0f);
		int_enable <= 1'b1;
		for (int m = 2; m < 4; m++) begin
			uca_node_model_i.cpb = (m == 2) ? 64 : 16;
			uca_node_model_i.nbits = 11;
			c0 = uca_node_model_i.got_cnt;
			wr(ADR_PORT_CONTROL, {m[1:0], 6'h08});
			wr(ADR_DATA_BUFFER, 8'h5a);
			wr(ADR_DATA_BUFFER, 8'hc3);
			n = 0;
			while (uca_node_model_i.got_cnt == c0 && n < 2000) begin
				@(posedge clk_sys);
				n++;
			end
			// A frame that never arrives must not pass on a stale byte
			if (uca_node_model_i.got_cnt == c0)
				errors++;
			`CHK("tx byte", 8'h5a, uca_node_model_i.got_byte)
			`CHK("tx ninth", 1'b1, uca_node_model_i.got_ninth)
			rdc("tx flag", ADR_PORT_CONTROL, {m[1:0], 6'h0a});
			`CHK("irq set", 1'b1, irq)
			int_enable <= 1'b0;
			repeat (3) @(posedge clk_sys);
			`CHK("irq masked", 1'b0, irq)
			int_enable <= 1'b1;
			wr(ADR_AUX_CONTROL, 8'h01);
			rdc("collision", ADR_PORT_CONTROL, 8'h2a);
			wr(ADR_PORT_CONTROL, 8'h00);
			wr(ADR_AUX_CONTROL, 8'h00);
			rdc("mode kept", ADR_PORT_CONTROL, {m[1:0], 6'h00});
			repeat (3) @(posedge clk_sys);
			`CHK("irq clear", 1'b0, irq)
		end
		rx_case(2'b11, 1'b1, 1'b1, 8'h15, 1'b1, 1'b1, 1'b1, 1'b1);
		rx_case(2'b11, 1'b1, 1'b1, 8'h16, 1'b1, 1'b1, 1'b0, 1'b0);
		rx_case(2'b11, 1'b1, 1'b1, 8'hff, 1'b1, 1'b1, 1'b1, 1'b1);
		rx_case(2'b10, 1'b1, 1'b1, 8'h15, 1'b0, 1'b1, 1'b0, 1'b0);
		rx_case(2'b11, 1'b0, 1'b1, 8'h16, 1'b1, 1'b1, 1'b1, 1'b1);
		rx_case(2'b10, 1'b0, 1'b1, 8'h40, 1'b0, 1'b1, 1'b1, 1'b0);
		rx_case(2'b11, 1'b0, 1'b0, 8'h15, 1'b1, 1'b1, 1'b0, 1'b0);
		rx_case(2'b11, 1'b0, 1'b1, 8'h11, 1'b0, 1'b1, 1'b1, 1'b0);
		uca_node_model_i.send(8'h22, 1'b0, 1'b1);
		uca_node_model_i.send(8'h33, 1'b0, 1'b1);
		repeat (8) @(posedge clk_sys);
		wr(ADR_AUX_CONTROL, 8'h01);
		rdc("overrun", ADR_PORT_CONTROL, 8'h51);
		rdc("latest byte", ADR_DATA_BUFFER, 8'h33);
		wr(ADR_PORT_CONTROL, 8'h00);
		rx_case(2'b01, 1'b1, 1'b1, 8'h5a, 1'b0, 1'b0, 1'b0, 1'b0);
		rx_case(2'b01, 1'b0, 1'b1, 8'h5a, 1'b0, 1'b0, 1'b1, 1'b0);
		rx_case(2'b01, 1'b0, 1'b1, 8'ha6, 1'b0, 1'b1, 1'b1, 1'b1);
		wr(ADR_AUX_CONTROL, 8'h01);
		rdc("framing", ADR_PORT_CONTROL, 8'h95);
		// Sync mode with multiprocessor enable set: eight clocked bits, flag after the last
		wr(ADR_AUX_CONTROL, 8'h00);
		wr(ADR_PORT_CONTROL, 8'h20);
		c0 = uca_node_model_i.sclk_cnt;
		wr(ADR_DATA_BUFFER, 8'ha5);
		repeat (120) @(posedge clk_sys);
		`CHK("sync clocks", 8, uca_node_model_i.sclk_cnt - c0)
		`CHK("sync byte", 8'ha5, uca_node_model_i.sync_byte)
		rdc("sync flag", ADR_PORT_CONTROL, 8'h22);
		report_and_stop();
	end
endmodule
